// ===== rtl/adccfg_bank.sv
// Module: converter configuration register bank and sample output path
`default_nettype none
module adccfg_bank #(
  parameter bit SHORT_VARIANT = 1'b0
) (
  input  wire logic                                  clk,
  input  wire logic                                  arst_n,
  input  wire logic                                  reg_wr_en,
  input  wire logic [adccfg_pkg::ADDR_W-1:0]         reg_addr,
  input  wire logic [adccfg_pkg::DATA_W-1:0]         reg_wr_data,
  output logic      [adccfg_pkg::DATA_W-1:0]         reg_rd_data,
  input  wire logic                                  format_select_pin,
  input  wire logic [adccfg_pkg::SAMPLE_W-1:0]       sample_in,
  output logic      [adccfg_pkg::SAMPLE_W-1:0]       data_out,
  output logic      [adccfg_pkg::SAMPLE_W-1:0]       data_out_en,
  output adccfg_pkg::adccfg_ctrl_t                   ctrl
);
  localparam int unsigned NREG = 13;
  localparam int unsigned SW = adccfg_pkg::SAMPLE_W;

  typedef logic [7:0] adccfg_byte_t;
  localparam adccfg_byte_t REG_ADDR [NREG] = '{
    adccfg_pkg::ADDR_SW_RESET, adccfg_pkg::ADDR_SWING, adccfg_pkg::ADDR_TEST_SEL,
    adccfg_pkg::ADDR_DC_ENABLE, adccfg_pkg::ADDR_PAT_HIGH, adccfg_pkg::ADDR_PAT_LOW,
    adccfg_pkg::ADDR_IF_CTRL, adccfg_pkg::ADDR_FALL_LAT, adccfg_pkg::ADDR_POWER,
    adccfg_pkg::ADDR_HF_TUNE, adccfg_pkg::ADDR_PEDESTAL, adccfg_pkg::ADDR_LOOP,
    adccfg_pkg::ADDR_RATE};
  localparam adccfg_byte_t REG_MASK [NREG] = '{
    adccfg_pkg::MASK_SW_RESET, adccfg_pkg::MASK_SWING, adccfg_pkg::MASK_TEST_SEL,
    adccfg_pkg::MASK_DC_EN, adccfg_pkg::MASK_PAT_HIGH, adccfg_pkg::MASK_PAT_LOW,
    adccfg_pkg::MASK_IF_CTRL, adccfg_pkg::MASK_FALL_LAT, adccfg_pkg::MASK_POWER,
    adccfg_pkg::MASK_HF_TUNE, adccfg_pkg::MASK_PED, adccfg_pkg::MASK_LOOP,
    adccfg_pkg::MASK_RATE};
  localparam int unsigned I_RST = 0;
  localparam int unsigned I_SWG = 1;
  localparam int unsigned I_TST = 2;
  localparam int unsigned I_DCE = 3;
  localparam int unsigned I_PH  = 4;
  localparam int unsigned I_PL  = 5;
  localparam int unsigned I_IF  = 6;
  localparam int unsigned I_FL  = 7;
  localparam int unsigned I_PWR = 8;
  localparam int unsigned I_HF  = 9;
  localparam int unsigned I_PED = 10;
  localparam int unsigned I_LP  = 11;
  localparam int unsigned I_RT  = 12;

  adccfg_byte_t   regs_reg [NREG];
  logic [NREG-1:0] hit;
  logic            soft_reset;
  logic [SW-1:0]   user_word;
  logic [SW-1:0]   user_mapped;
  logic [SW-1:0]   loop_out;
  logic [SW-1:0]   data_next;
  logic            digital_on;
  logic            test_user;
  logic            outputs_dead;
  logic [1:0]      if_field;
  logic            dc_en;
  logic [2:0]      pin_sync_reg;
  logic            pin_level_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  // Self-clearing soft reset
  assign soft_reset = regs_reg[I_RST][adccfg_pkg::SW_RESET_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      assign hit[gi] = reg_wr_en && (reg_addr == REG_ADDR[gi]);
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          regs_reg[gi] <= adccfg_pkg::REG_RESET_VAL;
        end else if (soft_reset) begin
          regs_reg[gi] <= adccfg_pkg::REG_RESET_VAL;
        end else if (hit[gi]) begin
          regs_reg[gi] <= reg_wr_data & REG_MASK[gi];
        end
      end
    end
  endgenerate

  // Readback mux; unmapped addresses read zero
  always_comb begin
    reg_rd_data = '0;
    for (int i = 0; i < NREG; i++) begin
      if (reg_addr == REG_ADDR[i]) begin
        reg_rd_data = regs_reg[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control decode
  assign if_field = regs_reg[I_IF][adccfg_pkg::IF_SEL_LSB +: 2];

  // Format pin crosses in through three flops; a new level counts once the last two agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync_reg  <= '0;
      pin_level_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], format_select_pin};
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
        pin_level_reg <= pin_sync_reg[2];
      end
    end
  end

  assign ctrl.if_mode = (if_field == adccfg_pkg::IF_FORCE_LVDS) ? adccfg_pkg::ADCCFG_IF_LVDS :
                        (if_field == adccfg_pkg::IF_FORCE_CMOS) ? adccfg_pkg::ADCCFG_IF_CMOS :
                        (pin_level_reg ? adccfg_pkg::ADCCFG_IF_CMOS
                                           : adccfg_pkg::ADCCFG_IF_LVDS);

  assign ctrl.rise_adjust = regs_reg[I_IF][adccfg_pkg::RISE_EN_BIT];
  assign ctrl.rise_offset = ctrl.rise_adjust ?
                            regs_reg[I_IF][adccfg_pkg::RISE_OFF_LSB +: 2] :
                            adccfg_pkg::EDGE_DEFAULT;
  assign ctrl.fall_adjust = regs_reg[I_IF][adccfg_pkg::FALL_EN_BIT];
  assign ctrl.fall_offset = ctrl.fall_adjust ?
                            regs_reg[I_FL][adccfg_pkg::FALL_OFF_LSB +: 2] :
                            adccfg_pkg::EDGE_DEFAULT;
  assign ctrl.lvds_align = (ctrl.if_mode == adccfg_pkg::ADCCFG_IF_LVDS) &&
                           ((ctrl.rise_offset == adccfg_pkg::EDGE_ALIGN) ||
                            (ctrl.fall_offset == adccfg_pkg::EDGE_ALIGN));

  assign digital_on      = regs_reg[I_FL][adccfg_pkg::SHORT_OFF_BIT];
  assign ctrl.short_path = !digital_on;

  assign ctrl.converter_off = regs_reg[I_FL][adccfg_pkg::QSLEEP_BIT] ||
                              regs_reg[I_PWR][adccfg_pkg::FSLEEP_BIT];
  assign ctrl.reference_off = regs_reg[I_PWR][adccfg_pkg::FSLEEP_BIT];
  assign ctrl.driver_off    = regs_reg[I_PWR][adccfg_pkg::DRV_OFF_BIT];

  assign ctrl.swing_apply = (regs_reg[I_PWR][adccfg_pkg::SWING_EN_LSB +: 2]
                             == adccfg_pkg::SWING_ON);
  assign ctrl.swing_code  = ctrl.swing_apply ?
                            regs_reg[I_SWG][adccfg_pkg::FIELD_LSB +: 6] : 6'h00;
  assign ctrl.hf_tuning   = regs_reg[I_HF][0];
  assign ctrl.low_rate    = regs_reg[I_RT][0];

  ////////////////////////////////////////////////////////////////////////////
  // Sample datapath
  // Low word from bits 7..2
  assign user_word = {regs_reg[I_PH], regs_reg[I_PL][adccfg_pkg::FIELD_LSB +: 6]};

  assign user_mapped = SHORT_VARIANT ?
                       {2'b00, user_word[SW-1:SW-adccfg_pkg::SHORT_W]} : user_word;

  // Loop enable gated by digital path
  assign dc_en = regs_reg[I_DCE][adccfg_pkg::DC_EN_BIT] && digital_on;

  adccfg_dc_loop u_dc_loop (
    .clk        (clk),
    .arst_n     (arst_n),
    .soft_clear (soft_reset),
    .loop_en    (dc_en),
    .loop_hold  (regs_reg[I_LP][adccfg_pkg::HOLD_BIT]),
    .loop_span  (regs_reg[I_LP][adccfg_pkg::FIELD_LSB +: adccfg_pkg::SPAN_W]),
    .pedestal   (regs_reg[I_PED][adccfg_pkg::FIELD_LSB +: adccfg_pkg::PED_W]),
    .sample_in  (sample_in),
    .sample_out (loop_out)
  );

  // User word on test code 101
  assign test_user = digital_on &&
                     (regs_reg[I_TST][adccfg_pkg::TEST_SEL_LSB +: 3] == adccfg_pkg::TEST_USER);
  assign data_next = test_user ? user_mapped : loop_out;
  assign outputs_dead = ctrl.driver_off || ctrl.converter_off;

  // Output data register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= '0;
    end else if (outputs_dead) begin
      data_out <= '0;
    end else begin
      data_out <= data_next;
    end
  end

  // Tristate enables off when powered down
  assign data_out_en = outputs_dead ? '0 : '1;
endmodule : adccfg_bank
`default_nettype wire

// ===== rtl/adccfg_pkg.sv
// Package: register map, field positions and control types of the converter config bank
`default_nettype none
package adccfg_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SAMPLE_W = 14;
  localparam int unsigned SHORT_W = 12;
  localparam int unsigned PED_W = 6;
  localparam int unsigned SPAN_W = 4;
  // Register offsets
  localparam logic [7:0] ADDR_SW_RESET    = 8'h00;
  localparam logic [7:0] ADDR_SWING       = 8'h01;
  localparam logic [7:0] ADDR_TEST_SEL    = 8'h25;
  localparam logic [7:0] ADDR_DC_ENABLE   = 8'h3d;
  localparam logic [7:0] ADDR_PAT_HIGH    = 8'h3f;
  localparam logic [7:0] ADDR_PAT_LOW     = 8'h40;
  localparam logic [7:0] ADDR_IF_CTRL     = 8'h41;
  localparam logic [7:0] ADDR_FALL_LAT    = 8'h42;
  localparam logic [7:0] ADDR_POWER       = 8'h43;
  localparam logic [7:0] ADDR_HF_TUNE     = 8'h4a;
  localparam logic [7:0] ADDR_PEDESTAL    = 8'hbf;
  localparam logic [7:0] ADDR_LOOP        = 8'hcf;
  localparam logic [7:0] ADDR_RATE        = 8'hdb;
  localparam logic [7:0] REG_RESET_VAL    = 8'h00;
  // Write masks: reserved bits are never stored
  localparam logic [7:0] MASK_SW_RESET = 8'h02;
  localparam logic [7:0] MASK_SWING    = 8'hfc;
  localparam logic [7:0] MASK_TEST_SEL = 8'h07;
  localparam logic [7:0] MASK_DC_EN    = 8'h20;
  localparam logic [7:0] MASK_PAT_HIGH = 8'hff;
  localparam logic [7:0] MASK_PAT_LOW  = 8'hfc;
  localparam logic [7:0] MASK_IF_CTRL  = 8'hcf;
  localparam logic [7:0] MASK_FALL_LAT = 8'hcc;
  localparam logic [7:0] MASK_POWER    = 8'h53;
  localparam logic [7:0] MASK_HF_TUNE  = 8'h01;
  localparam logic [7:0] MASK_PED      = 8'hfc;
  localparam logic [7:0] MASK_LOOP     = 8'hbc;
  localparam logic [7:0] MASK_RATE     = 8'h01;
  // Field positions
  localparam int unsigned SW_RESET_BIT   = 1;
  localparam int unsigned DC_EN_BIT      = 5;
  localparam int unsigned IF_SEL_LSB     = 6;
  localparam int unsigned RISE_EN_BIT    = 3;
  localparam int unsigned RISE_OFF_LSB   = 1;
  localparam int unsigned FALL_EN_BIT    = 0;
  localparam int unsigned FALL_OFF_LSB   = 6;
  localparam int unsigned SHORT_OFF_BIT  = 3;
  localparam int unsigned QSLEEP_BIT     = 2;
  localparam int unsigned FSLEEP_BIT     = 6;
  localparam int unsigned DRV_OFF_BIT    = 4;
  localparam int unsigned SWING_EN_LSB   = 0;
  localparam int unsigned FIELD_LSB      = 2;
  localparam int unsigned HOLD_BIT       = 7;
  localparam int unsigned TEST_SEL_LSB   = 0;
  // Codes
  localparam logic [1:0] IF_FORCE_LVDS = 2'h1;
  localparam logic [1:0] IF_FORCE_CMOS = 2'h3;
  localparam logic [1:0] EDGE_DEFAULT  = 2'h0;
  localparam logic [1:0] EDGE_ALIGN    = 2'h2;
  localparam logic [1:0] SWING_ON      = 2'h3;
  localparam logic [2:0] TEST_USER     = 3'h5;
  localparam logic [13:0] MID_CODE     = 14'h2000;
  localparam logic [4:0] SPAN_BASE_LOG2 = 5'h14;   // 1M cycles = 2**20
  localparam logic [3:0] SPAN_MAX      = 4'hb;
  localparam int unsigned ACC_W        = 48;

  typedef enum logic [1:0] {
    ADCCFG_IF_PIN  = 2'h0,
    ADCCFG_IF_LVDS = 2'h1,
    ADCCFG_IF_CMOS = 2'h3
  } adccfg_if_t;

  typedef struct packed {
    adccfg_if_t  if_mode;
    logic        rise_adjust;
    logic [1:0]  rise_offset;
    logic        fall_adjust;
    logic [1:0]  fall_offset;
    logic        lvds_align;
    logic        short_path;
    logic        converter_off;
    logic        reference_off;
    logic        driver_off;
    logic        swing_apply;
    logic [5:0]  swing_code;
    logic        hf_tuning;
    logic        low_rate;
  } adccfg_ctrl_t;
endpackage : adccfg_pkg
`default_nettype wire

// ===== rtl/adccfg_dc_loop.sv
// Module: dc offset correction loop with hold, pedestal and programmable span
`default_nettype none
module adccfg_dc_loop (
  input  wire logic                                  clk,
  input  wire logic                                  arst_n,
  input  wire logic                                  soft_clear,
  input  wire logic                                  loop_en,
  input  wire logic                                  loop_hold,
  input  wire logic [adccfg_pkg::SPAN_W-1:0]         loop_span,
  input  wire logic [adccfg_pkg::PED_W-1:0]          pedestal,
  input  wire logic [adccfg_pkg::SAMPLE_W-1:0]       sample_in,
  output logic      [adccfg_pkg::SAMPLE_W-1:0]       sample_out
);
  localparam int unsigned AW = adccfg_pkg::ACC_W;
  localparam int unsigned SW = adccfg_pkg::SAMPLE_W;

  logic signed [AW-1:0] acc_reg;
  logic signed [AW-1:0] acc_next;
  logic        [4:0]    shift_amt;
  logic signed [SW+1:0] target;
  logic signed [SW+1:0] error;
  logic signed [SW+1:0] offset_est;
  logic signed [SW+1:0] corrected;

  // Target level is mid-code plus the signed pedestal
  // converge to the target level
  assign target = $signed({2'b00, adccfg_pkg::MID_CODE})
                + (SW+2)'($signed(pedestal));
  assign error = $signed({2'b00, sample_in}) - offset_est - target;
  assign shift_amt = adccfg_pkg::SPAN_BASE_LOG2
                   + 5'((loop_span > adccfg_pkg::SPAN_MAX) ? adccfg_pkg::SPAN_MAX : loop_span);
  assign offset_est = (SW+2)'(acc_reg >>> shift_amt);
  assign acc_next = acc_reg + AW'(error);
  assign corrected = $signed({2'b00, sample_in}) - offset_est;

  // Offset estimate integrator
  // hold keeps last estimate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= '0;
    end else if (soft_clear || !loop_en) begin
      acc_reg <= '0;
    end else if (!loop_hold) begin
      acc_reg <= acc_next;
    end
  end

  // Corrected sample, clipped to code range
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_out <= '0;
    end else if (!loop_en) begin
      sample_out <= sample_in;
    end else if (corrected < 0) begin
      sample_out <= '0;
    end else if (corrected[SW+1:SW] != 2'b00) begin
      sample_out <= '1;
    end else begin
      sample_out <= corrected[SW-1:0];
    end
  end
endmodule : adccfg_dc_loop
`default_nettype wire

// ===== testbench/adccfg_bank_asserts.sv
// Checker: port-level assertions for the converter config bank
`default_nettype none
module adccfg_bank_asserts (
  input wire logic                            clk,
  input wire logic                            arst_n,
  input wire logic                            reg_wr_en,
  input wire logic [adccfg_pkg::ADDR_W-1:0]   reg_addr,
  input wire logic [adccfg_pkg::DATA_W-1:0]   reg_wr_data,
  input wire logic [adccfg_pkg::DATA_W-1:0]   reg_rd_data,
  input wire logic                            format_select_pin,
  input wire logic [adccfg_pkg::SAMPLE_W-1:0] sample_in,
  input wire logic [adccfg_pkg::SAMPLE_W-1:0] data_out,
  input wire logic [adccfg_pkg::SAMPLE_W-1:0] data_out_en,
  input wire adccfg_pkg::adccfg_ctrl_t        ctrl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic w00;
  logic w41;
  logic w42;
  logic w43;
  // Write decodes per register
  assign w00 = reg_wr_en && reg_addr == adccfg_pkg::ADDR_SW_RESET;
  assign w41 = reg_wr_en && reg_addr == adccfg_pkg::ADDR_IF_CTRL;
  assign w42 = reg_wr_en && reg_addr == adccfg_pkg::ADDR_FALL_LAT;
  assign w43 = reg_wr_en && reg_addr == adccfg_pkg::ADDR_POWER;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_if_forced: assert property (w41 && reg_wr_data[6] |=>
    ctrl.if_mode == ($past(reg_wr_data[7]) ? adccfg_pkg::ADCCFG_IF_CMOS
    : adccfg_pkg::ADCCFG_IF_LVDS)) else $error("forced interface wrong");
  chk_if_pin: assert property (w41 && !reg_wr_data[6] |=>
    ctrl.if_mode == (format_select_pin ? adccfg_pkg::ADCCFG_IF_CMOS
    : adccfg_pkg::ADCCFG_IF_LVDS)) else $error("pin interface wrong");
  chk_rise_gate: assert property (!ctrl.rise_adjust |-> ctrl.rise_offset == 2'h0)
    else $error("rise offset not gated");
  chk_rise_load: assert property (w41 && reg_wr_data[3] |=>
    ctrl.rise_offset == $past(reg_wr_data[2:1])) else $error("rise offset lost");
  chk_fall_gate: assert property (!ctrl.fall_adjust |-> ctrl.fall_offset == 2'h0)
    else $error("fall offset not gated");
  chk_swing_gate: assert property (w43 |=>
    ctrl.swing_apply == ($past(reg_wr_data[1:0]) == 2'h3)) else $error("swing gate wrong");
  chk_short_path: assert property (w42 |=> ctrl.short_path == !$past(reg_wr_data[3]))
    else $error("short path wrong");
  chk_drv_tristate: assert property (ctrl.driver_off || ctrl.converter_off |->
    data_out_en == 14'h0) else $error("outputs still enabled");
  chk_full_sleep: assert property (w43 && reg_wr_data[6] |=>
    ctrl.reference_off && ctrl.converter_off && data_out_en == 14'h0)
    else $error("full sleep incomplete");
  chk_reset_zero: assert property ($rose(arst_n) |-> reg_rd_data == 8'h00)
    else $error("register not zero after reset");
  chk_soft_clear: assert property (w00 && reg_wr_data[1] ##1 !reg_wr_en |=>
    ctrl.short_path && !ctrl.low_rate && !ctrl.hf_tuning) else $error("soft reset failed");
endmodule : adccfg_bank_asserts
bind adccfg_bank adccfg_bank_asserts u_chk (.clk, .arst_n, .reg_wr_en, .reg_addr,
  .reg_wr_data, .reg_rd_data, .format_select_pin, .sample_in, .data_out, .data_out_en, .ctrl);
`default_nettype wire

// ===== testbench/adccfg_host.sv
// Host model: register writes and reads over the bank's register port
`default_nettype none
module adccfg_host (
  input  wire logic       clk,
  output var logic        reg_wr_en,
  output var logic [7:0]  reg_addr,
  output var logic [7:0]  reg_wr_data,
  input  wire logic [7:0] reg_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    reg_wr_en = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
  end
  // One write: strobe up for a single edge, data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    reg_wr_data <= ~d;
  endtask : wr
  // One read: address set, value taken at the next edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    d = reg_rd_data;
  endtask : rd
endmodule : adccfg_host
`default_nettype wire

// ===== testbench/tb_adccfg_bank.sv
// Testbench: register map, decode and output path of the converter config bank
`default_nettype none
`define CHK(g, e) cmp(g, e)
module tb_adccfg_bank;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic pin = 1'b0;
  logic [13:0] smp = 14'h1234;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdat;
  logic [7:0] rdat;
  logic [7:0] rv;
  logic [13:0] rv14;
  logic [13:0] hold14;
  logic [13:0] dout;
  logic [13:0] d12;
  logic [13:0] oen;
  adccfg_pkg::adccfg_ctrl_t ctrl;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  // Rows: address, written value, expected readback
  logic [23:0] rows [13] = '{24'h01fcfc, 24'h250707, 24'h3d2020, 24'h3fffff, 24'h40fcfc,
    24'h41cfcf, 24'h42cccc, 24'h435353, 24'h4a0101, 24'hbffcfc, 24'hcfbcbc, 24'hdb0101,
    24'h260300};
  always #50 clk = ~clk;
  adccfg_host host (.clk, .reg_wr_en(wr_en), .reg_addr(addr), .reg_wr_data(wdat),
    .reg_rd_data(rdat));
  adccfg_bank #(.SHORT_VARIANT(1'b0)) uut (.clk, .arst_n, .reg_wr_en(wr_en), .reg_addr(addr),
    .reg_wr_data(wdat), .reg_rd_data(rdat), .format_select_pin(pin), .sample_in(smp),
    .data_out(dout), .data_out_en(oen), .ctrl);
  adccfg_bank #(.SHORT_VARIANT(1'b1)) uut2 (.clk, .arst_n, .reg_wr_en(wr_en),
    .reg_addr(addr), .reg_wr_data(wdat), .reg_rd_data(), .format_select_pin(pin),
    .sample_in(smp), .data_out(d12), .data_out_en(), .ctrl());
  // Compare and count
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic end_sim;
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic do_reset;
    arst_n <= 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
  endtask : do_reset
  // Write, then wait until decoded outputs have settled
  task automatic wrs(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    @(negedge clk);
  endtask : wrs
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    do_reset();
    // Table sets every defined bit except the soft reset bit at 0x00 and leaves reserved bits zero
    foreach (rows[i]) begin
      host.wr(rows[i][23:16], rows[i][15:8]);
      host.rd(rows[i][23:16], rv);
      `CHK(rv, rows[i][7:0]);
    end
    do_reset();
    foreach (rows[i]) begin
      host.rd(rows[i][23:16], rv);
      `CHK(rv, 8'h00);
    end
    `CHK(oen, 14'h3fff);
    // Pin held five cycles so its synchroniser settles before the write
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) pin <= i[0];
      repeat (5) @(posedge clk);
      wrs(8'h41, {i[2:1], 6'h00});
      `CHK(ctrl.if_mode, {i[1] ? i[2] : i[0], 1'b1});
    end
    wrs(8'h41, 8'h44);
    `CHK(ctrl.rise_offset, 2'h0);
    wrs(8'h41, 8'h4d);
    `CHK({ctrl.rise_adjust, ctrl.rise_offset}, 3'h6);
    `CHK(ctrl.lvds_align, 1'b1);
    wrs(8'h42, 8'h80);
    `CHK(ctrl.fall_offset, 2'h2);
    wrs(8'h41, 8'h40);
    `CHK(ctrl.fall_offset, 2'h0);
    `CHK(ctrl.lvds_align, 1'b0);
    wrs(8'h3f, 8'ha5);
    wrs(8'h40, 8'h58);
    wrs(8'h25, 8'h05);
    wrs(8'h42, 8'h08);
    repeat (2) @(negedge clk);
    `CHK(dout, 14'h2956);
    `CHK(d12, 14'h0a55);
    wrs(8'h42, 8'h00);
    repeat (3) @(negedge clk);
    `CHK(dout, 14'h1234);
    wrs(8'h42, 8'h0c);
    `CHK({ctrl.converter_off, ctrl.reference_off, oen}, {2'h2, 14'h0});
    wrs(8'h42, 8'h08);
    wrs(8'h43, 8'h40);
    `CHK({ctrl.converter_off, ctrl.reference_off}, 2'h3);
    wrs(8'h43, 8'h10);
    `CHK({ctrl.driver_off, oen}, {1'b1, 14'h0});
    wrs(8'h43, 8'h00);
    `CHK(oen, 14'h3fff);
    wrs(8'h01, 8'hd8);
    wrs(8'h43, 8'h03);
    `CHK({ctrl.swing_apply, ctrl.swing_code}, 7'h76);
    wrs(8'h43, 8'h00);
    `CHK({ctrl.swing_apply, ctrl.swing_code}, 7'h00);
    wrs(8'h4a, 8'h01);
    `CHK(ctrl.hf_tuning, 1'b1);
    wrs(8'hdb, 8'h01);
    `CHK(ctrl.low_rate, 1'b1);
    // Correction pulls a low sample toward mid-code, more slowly at a longer span
    wrs(8'h25, 8'h00);
    wrs(8'h3d, 8'h20);
    repeat (1000) @(negedge clk);
    rv14 = dout;
    `CHK(rv14 > 14'h1234 && rv14 < 14'h2000, 1'b1);
    wrs(8'hcf, 8'h80);
    repeat (3) @(negedge clk);
    hold14 = dout;
    repeat (1000) @(negedge clk);
    `CHK(dout, hold14);
    wrs(8'h3d, 8'h00);
    repeat (3) @(negedge clk);
    `CHK(dout, 14'h1234);
    wrs(8'hcf, 8'h04);
    wrs(8'h3d, 8'h20);
    repeat (1000) @(negedge clk);
    `CHK(dout > 14'h1234 && dout < rv14, 1'b1);
    // Sample at mid-code stays put; a positive pedestal lifts it
    wrs(8'h3d, 8'h00);
    @(posedge clk) smp <= 14'h2000;
    wrs(8'hcf, 8'h00);
    wrs(8'h3d, 8'h20);
    repeat (20) @(negedge clk);
    `CHK(dout, 14'h2000);
    wrs(8'hbf, 8'h7c);
    repeat (20) @(negedge clk);
    `CHK(dout > 14'h2000 && dout <= 14'h201f, 1'b1);
    wrs(8'h00, 8'h02);
    `CHK(rdat, 8'h02);
    @(negedge clk);
    `CHK({rdat, ctrl.low_rate, ctrl.hf_tuning}, 10'h000);
    end_sim();
  end
endmodule : tb_adccfg_bank
`default_nettype wire
